//--- common/bcq_pkg.sv
// Package: constants and carrier types for the sequencer timer/queue opcodes
package bcq_pkg;

  // ********************************************
  // Widths
  // ********************************************
  localparam int DW = 16;
  localparam int AW = 16;
  localparam int RAW = 4;
  localparam int NFLAG = 8;
  localparam int OPW = 8;
  localparam int FLAG_HI_OFS = 8;

  // ********************************************
  // Opcodes (low byte of the opcode word)
  // ********************************************
  localparam logic [OPW-1:0] OPC_FLAG = 8'h0C;
  localparam logic [OPW-1:0] OPC_LOAD_TT = 8'h0D;
  localparam logic [OPW-1:0] OPC_LOAD_FT = 8'h0E;
  localparam logic [OPW-1:0] OPC_START_FT = 8'h0F;
  localparam logic [OPW-1:0] OPC_PUSH_TT = 8'h10;
  localparam logic [OPW-1:0] OPC_PUSH_BSW = 8'h11;
  localparam logic [OPW-1:0] OPC_PUSH_IMM = 8'h12;
  localparam logic [OPW-1:0] OPC_PUSH_IND = 8'h13;
  localparam logic [OPW-1:0] OPC_WAIT_TRIG = 8'h14;
  localparam logic [OPW-1:0] OPC_EXEC_FLIP = 8'h15;
  localparam logic [DW-1:0] FLIP_MASK = 16'h0010;

  // ********************************************
  // Register indices, fields and reset values
  // ********************************************
  localparam logic [RAW-1:0] REG_CONFIG = 4'h0;
  localparam logic [RAW-1:0] REG_STATUS = 4'h1;
  localparam logic [RAW-1:0] REG_INSTR_PTR = 4'h2;
  localparam logic [RAW-1:0] REG_QUEUE_PTR = 4'h3;
  localparam logic [RAW-1:0] REG_TIME_TAG = 4'h4;
  localparam logic [RAW-1:0] REG_FRAME_TIMER = 4'h5;
  localparam logic [RAW-1:0] REG_FRAME_COUNT = 4'h6;
  localparam logic [RAW-1:0] REG_GP_FLAGS = 4'h7;
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_RES_LO = 7;
  localparam int CFG_RES_HI = 9;
  localparam logic [DW-1:0] CONFIG_RST = 16'h0000;
  localparam logic [AW-1:0] PTR_RST = 16'h0000;
  localparam logic [2:0] RES_STOP = 3'h7;
  localparam logic [6:0] RES_BASE_US = 7'h40;

  // ********************************************
  // Timing
  // ********************************************
  localparam int CLK_MHZ = 100;
  localparam int US_CYC = CLK_MHZ;
  localparam int FRAME_LSB_US = 100;
  localparam int FRAME_LSB_CYC = FRAME_LSB_US * US_CYC;

  // ********************************************
  // Types
  // ********************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [RAW-1:0] addr;
    logic [DW-1:0] wdata;
  } bcq_reg_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } bcq_mem_req_t;

  typedef enum logic [3:0] {
    S_IDLE, S_FOP, S_FPAR, S_FOPD, S_FPARD, S_EXEC, S_IND, S_INDD,
    S_PUSH, S_TRIG, S_MSG, S_FLIP, S_NEXT
  } bcq_state_t;

endpackage

//--- verilog/bcq_flag_unit.sv
// General purpose flags with per-flag set/clear/toggle pair encoding
`timescale 1ns/1ns
module bcq_flag_unit #(
  parameter int NF = bcq_pkg::NFLAG
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic apply,
  input wire logic [bcq_pkg::DW-1:0] ctl,
  output logic [NF-1:0] flags
);
  import bcq_pkg::*;

  // ********************************************
  // One flip-flop per flag, pair {n+8,n} picks the action
  // ********************************************
  for (genvar i = 0; i < NF; i++) begin : g_flag
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        flags[i] <= 1'b0;
      end else if (clk_en && apply) begin
        case ({ctl[i+FLAG_HI_OFS], ctl[i]})
          2'h1: flags[i] <= 1'b1;
          2'h2: flags[i] <= 1'b0;
          2'h3: flags[i] <= ~flags[i];
          default: flags[i] <= flags[i];
        endcase
      end
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  property p_flag_toggle;
    @(posedge clock) disable iff (!resetn)
    (clk_en && apply && ctl[0] && ctl[FLAG_HI_OFS]) |=> (flags[0] != $past(flags[0]));
  endproperty
  a_flag_toggle: assert property (p_flag_toggle) else $error("flag 0 did not toggle");

endmodule

//--- verilog/bcq_seq_ops.sv
// Sequencer execution of timer, queue, trigger, flag and execute-flip opcodes
//
// Summary of operation
// - Flag pair per bit: keep, set, clear, toggle
// - Opcode 0D true loads time tag counter
// - Time tag LSB follows config bits 9..7
// - Opcode 0E true loads frame timer register
// - Opcode 0F true starts frame counter
// - Opcode 10 true pushes time tag
// - Opcode 11 true pushes last block status
// - Opcode 12 true pushes parameter word
// - Opcode 13 true pushes word at parameter
// - Opcode 14 true waits for trigger edge
// - Opcode 15 always processes message at parameter
// - After message, true condition flips parameter bit 4
// - Next pass uses flipped address; false keeps it
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
module bcq_seq_ops #(
  parameter int FRAME_TICK_CYCLES = bcq_pkg::FRAME_LSB_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire bcq_pkg::bcq_reg_req_t reg_req,
  output logic [bcq_pkg::DW-1:0] reg_rdata,
  output bcq_pkg::bcq_mem_req_t mem_req,
  input wire logic [bcq_pkg::DW-1:0] mem_rdata,
  input wire logic cond_true,
  input wire logic [bcq_pkg::DW-1:0] block_status,
  input wire logic external_trigger_in,
  input wire logic msg_done,
  output logic msg_start,
  output logic [bcq_pkg::AW-1:0] msg_cba,
  output logic [bcq_pkg::NFLAG-1:0] gp_flags
);
  import bcq_pkg::*;

  localparam int FDW = $clog2(FRAME_TICK_CYCLES + 1);
  localparam int UDW = $clog2(US_CYC + 1);

  bcq_state_t state;
  bcq_mem_req_t mem_req_reg;
  logic [DW-1:0] config_reg;
  logic [AW-1:0] ip_reg;
  logic [AW-1:0] gpq_ptr_reg;
  logic [DW-1:0] time_tag_reg;
  logic [DW-1:0] frame_timer_reg;
  logic [DW-1:0] frame_count_reg;
  logic frame_run_reg;
  logic [OPW-1:0] op_reg;
  logic [DW-1:0] param_reg;
  logic [DW-1:0] push_data_reg;
  logic [DW-1:0] reg_rdata_reg;
  logic msg_start_reg;
  logic [AW-1:0] msg_cba_reg;
  logic trig_prev_reg;
  logic [UDW-1:0] us_div_reg;
  logic [6:0] lsb_cnt_reg;
  logic [FDW-1:0] frame_div_reg;
  logic run;
  logic exec;
  logic [2:0] res_sel;
  logic [6:0] lsb_us;
  logic us_wrap;
  logic tt_tick;
  logic frame_tick;
  logic trig_rise;
  logic flag_apply;
  logic [DW-1:0] flag_ctl;
  logic host_wr;

  // ********************************************
  // Decode helpers
  // ********************************************
  assign run = config_reg[CFG_RUN_BIT];
  assign exec = (state == S_EXEC);
  assign host_wr = reg_req.wr;
  assign res_sel = config_reg[CFG_RES_HI:CFG_RES_LO];
  assign lsb_us = RES_BASE_US >> res_sel;
  assign us_wrap = (us_div_reg == UDW'(US_CYC - 1));
  assign tt_tick = us_wrap && (lsb_cnt_reg >= lsb_us - 7'h01) && (res_sel != RES_STOP);
  assign frame_tick = (frame_div_reg == FDW'(FRAME_TICK_CYCLES - 1));
  // Trigger input is synchronous to clock, so one flop suffices
  assign trig_rise = external_trigger_in && !trig_prev_reg;

  // ********************************************
  // Sequencer state machine
  // ********************************************
  // Fetch is pipelined: opcode and parameter reads overlap by one cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
    end else if (clk_en) begin
      case (state)
        S_IDLE: state <= run ? S_FOP : S_IDLE;
        S_FOP: state <= S_FPAR;
        S_FPAR: state <= S_FOPD;
        S_FOPD: state <= S_FPARD;
        S_FPARD: state <= S_EXEC;
        S_EXEC: begin
          case (op_reg)
            OPC_PUSH_TT, OPC_PUSH_BSW, OPC_PUSH_IMM: state <= cond_true ? S_PUSH : S_NEXT;
            OPC_PUSH_IND: state <= cond_true ? S_IND : S_NEXT;
            OPC_WAIT_TRIG: state <= cond_true ? S_TRIG : S_NEXT;
            OPC_EXEC_FLIP: state <= S_MSG;
            default: state <= S_NEXT;
          endcase
        end
        S_IND: state <= S_INDD;
        S_INDD: state <= S_PUSH;
        S_PUSH: state <= S_NEXT;
        S_TRIG: state <= trig_rise ? S_NEXT : S_TRIG;
        S_MSG: begin
          if (msg_done) begin
            state <= cond_true ? S_FLIP : S_NEXT;
          end
        end
        S_FLIP: state <= S_NEXT;
        S_NEXT: state <= run ? S_FOP : S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // ********************************************
  // Opcode and parameter capture
  // ********************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      op_reg <= '0;
      param_reg <= '0;
    end else if (clk_en) begin
      if (state == S_FOPD) begin
        op_reg <= mem_rdata[OPW-1:0];
      end
      if (state == S_FPARD) begin
        param_reg <= mem_rdata;
      end
    end
  end

  // ********************************************
  // Word to push onto the queue
  // ********************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      push_data_reg <= '0;
    end else if (clk_en) begin
      if (exec && op_reg == OPC_PUSH_TT) begin
        push_data_reg <= time_tag_reg;
      end else if (exec && op_reg == OPC_PUSH_BSW) begin
        push_data_reg <= block_status;
      end else if (exec && op_reg == OPC_PUSH_IMM) begin
        push_data_reg <= param_reg;
      end else if (state == S_INDD) begin
        push_data_reg <= mem_rdata;
      end
    end
  end

  // ********************************************
  // Shared memory port, one-cycle strobes
  // ********************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_req_reg <= '0;
    end else if (clk_en) begin
      mem_req_reg.rd <= 1'b0;
      mem_req_reg.wr <= 1'b0;
      case (state)
        S_FOP: begin
          mem_req_reg.rd <= 1'b1;
          mem_req_reg.addr <= ip_reg;
        end
        S_FPAR: begin
          mem_req_reg.rd <= 1'b1;
          mem_req_reg.addr <= ip_reg + 16'h0001;
        end
        S_EXEC: begin
          if (op_reg == OPC_PUSH_IND && cond_true) begin
            mem_req_reg.rd <= 1'b1;
            mem_req_reg.addr <= param_reg;
          end
        end
        S_PUSH: begin
          mem_req_reg.wr <= 1'b1;
          mem_req_reg.addr <= gpq_ptr_reg;
          mem_req_reg.wdata <= push_data_reg;
        end
        S_FLIP: begin
          mem_req_reg.wr <= 1'b1;
          mem_req_reg.addr <= ip_reg + 16'h0001;
          mem_req_reg.wdata <= param_reg ^ FLIP_MASK;
        end
        default: mem_req_reg.addr <= mem_req_reg.addr;
      endcase
    end
  end

  // ********************************************
  // Instruction and queue pointers
  // ********************************************
  // Host may move the instruction pointer only while the engine is idle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ip_reg <= PTR_RST;
    end else if (clk_en) begin
      if (state == S_NEXT) begin
        ip_reg <= ip_reg + 16'h0002;
      end else if (state == S_IDLE && host_wr && reg_req.addr == REG_INSTR_PTR) begin
        ip_reg <= reg_req.wdata;
      end
    end
  end

  // A push wins over a host write in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gpq_ptr_reg <= PTR_RST;
    end else if (clk_en) begin
      if (state == S_PUSH) begin
        gpq_ptr_reg <= gpq_ptr_reg + 16'h0001;
      end else if (host_wr && reg_req.addr == REG_QUEUE_PTR) begin
        gpq_ptr_reg <= reg_req.wdata;
      end
    end
  end

  // ********************************************
  // Message hand-off
  // ********************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msg_start_reg <= 1'b0;
      msg_cba_reg <= '0;
    end else if (clk_en) begin
      msg_start_reg <= exec && op_reg == OPC_EXEC_FLIP;
      if (exec && op_reg == OPC_EXEC_FLIP) begin
        msg_cba_reg <= param_reg;
      end
    end
  end

  // ********************************************
  // Time tag counter with selectable resolution
  // ********************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      us_div_reg <= '0;
      lsb_cnt_reg <= '0;
    end else if (clk_en) begin
      us_div_reg <= us_wrap ? '0 : us_div_reg + UDW'(1);
      if (tt_tick) begin
        lsb_cnt_reg <= '0;
      end else if (us_wrap) begin
        lsb_cnt_reg <= lsb_cnt_reg + 7'h01;
      end
    end
  end

  // Opcode load wins over a tick and over a host write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      time_tag_reg <= '0;
    end else if (clk_en) begin
      if (exec && op_reg == OPC_LOAD_TT && cond_true) begin
        time_tag_reg <= param_reg;
      end else if (host_wr && reg_req.addr == REG_TIME_TAG) begin
        time_tag_reg <= reg_req.wdata;
      end else if (tt_tick) begin
        time_tag_reg <= time_tag_reg + 16'h0001;
      end
    end
  end

  // ********************************************
  // Frame timer register and frame time counter
  // ********************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_timer_reg <= '0;
    end else if (clk_en) begin
      if (exec && op_reg == OPC_LOAD_FT && cond_true) begin
        frame_timer_reg <= param_reg;
      end else if (host_wr && reg_req.addr == REG_FRAME_TIMER) begin
        frame_timer_reg <= reg_req.wdata;
      end
    end
  end

  // Counts down one LSB per 100 us and stops at zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_count_reg <= '0;
      frame_run_reg <= 1'b0;
      frame_div_reg <= '0;
    end else if (clk_en) begin
      if (exec && op_reg == OPC_START_FT && cond_true) begin
        frame_count_reg <= frame_timer_reg;
        frame_run_reg <= (frame_timer_reg != 16'h0000);
        frame_div_reg <= '0;
      end else if (frame_run_reg) begin
        frame_div_reg <= frame_tick ? '0 : frame_div_reg + FDW'(1);
        if (frame_tick) begin
          frame_count_reg <= frame_count_reg - 16'h0001;
          frame_run_reg <= (frame_count_reg != 16'h0001);
        end
      end
    end
  end

  // ********************************************
  // Trigger edge detect
  // ********************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trig_prev_reg <= 1'b0;
    end else if (clk_en) begin
      trig_prev_reg <= external_trigger_in;
    end
  end

  // ********************************************
  // General purpose flags
  // ********************************************
  // Opcode update takes the cycle; a host write in that cycle is dropped
  assign flag_apply = (exec && op_reg == OPC_FLAG) || (host_wr && reg_req.addr == REG_GP_FLAGS);
  assign flag_ctl = (exec && op_reg == OPC_FLAG) ? param_reg : reg_req.wdata;

  bcq_flag_unit #(
    .NF(NFLAG)
  ) u_flags (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .apply(flag_apply),
    .ctl(flag_ctl),
    .flags(gp_flags)
  );

  // ********************************************
  // Configuration and register read port
  // ********************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      config_reg <= CONFIG_RST;
    end else if (clk_en && host_wr && reg_req.addr == REG_CONFIG) begin
      config_reg <= reg_req.wdata;
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_reg <= '0;
    end else if (clk_en) begin
      reg_rdata_reg <= '0;
      if (reg_req.rd) begin
        case (reg_req.addr)
          REG_CONFIG: reg_rdata_reg <= config_reg;
          REG_STATUS: reg_rdata_reg <= {12'h000, frame_run_reg, state == S_MSG, state == S_TRIG, state != S_IDLE};
          REG_INSTR_PTR: reg_rdata_reg <= ip_reg;
          REG_QUEUE_PTR: reg_rdata_reg <= gpq_ptr_reg;
          REG_TIME_TAG: reg_rdata_reg <= time_tag_reg;
          REG_FRAME_TIMER: reg_rdata_reg <= frame_timer_reg;
          REG_FRAME_COUNT: reg_rdata_reg <= frame_count_reg;
          REG_GP_FLAGS: reg_rdata_reg <= {8'h00, gp_flags};
          default: reg_rdata_reg <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign mem_req = mem_req_reg;
  assign msg_start = msg_start_reg;
  assign msg_cba = msg_cba_reg;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_exec_true(logic [OPW-1:0] opc);
    clk_en && exec && op_reg == opc && cond_true;
  endsequence

  sequence s_flip_req;
    clk_en && state == S_MSG && msg_done && cond_true;
  endsequence

  property p_load_tt;
    s_exec_true(OPC_LOAD_TT) |=> time_tag_reg == $past(param_reg);
  endproperty
  a_load_tt: assert property (p_load_tt) else $error("time tag not loaded");

  property p_load_ft;
    s_exec_true(OPC_LOAD_FT) |=> frame_timer_reg == $past(param_reg);
  endproperty
  a_load_ft: assert property (p_load_ft) else $error("frame timer not loaded");

  property p_start_ft;
    s_exec_true(OPC_START_FT) |=> frame_count_reg == $past(frame_timer_reg);
  endproperty
  a_start_ft: assert property (p_start_ft) else $error("frame counter not started");

  property p_push_imm;
    s_exec_true(OPC_PUSH_IMM) |=> state == S_PUSH && push_data_reg == $past(param_reg);
  endproperty
  a_push_imm: assert property (p_push_imm) else $error("immediate not queued");

  property p_push_write;
    (clk_en && state == S_PUSH) |=> mem_req_reg.wr && mem_req_reg.addr == $past(gpq_ptr_reg)
      && gpq_ptr_reg == $past(gpq_ptr_reg) + 16'h0001;
  endproperty
  a_push_write: assert property (p_push_write) else $error("queue push wrong");

  property p_trig_skip;
    (clk_en && exec && op_reg == OPC_WAIT_TRIG && !cond_true) |=> state == S_NEXT;
  endproperty
  a_trig_skip: assert property (p_trig_skip) else $error("false wait stalled");

  property p_msg_start;
    (clk_en && exec && op_reg == OPC_EXEC_FLIP) |=> msg_start_reg && msg_cba_reg == $past(param_reg);
  endproperty
  a_msg_start: assert property (p_msg_start) else $error("message not started");

  property p_flip;
    s_flip_req ##1 (clk_en && state == S_FLIP) |=> mem_req_reg.wr && mem_req_reg.wdata == (param_reg ^ FLIP_MASK);
  endproperty
  a_flip: assert property (p_flip) else $error("parameter not flipped");

endmodule

//--- bench/bcq_ram_model.sv
// Shared RAM partner model for the sequencer memory port
`timescale 1ns/1ns
module bcq_ram_model
  import bcq_pkg::*;
(
  input wire logic clock,
  input wire bcq_pkg::bcq_mem_req_t mem_req,
  output logic [bcq_pkg::DW-1:0] mem_rdata
);
  logic [DW-1:0] mem [0:255];
  logic [DW-1:0] q = 16'h0000;
  logic rd_q = 1'b0;

  // Instruction and queue words share one array; only the low address byte is decoded
  always @(posedge clock) begin
    rd_q <= mem_req.rd;
    if (mem_req.rd) begin
      q <= mem[mem_req.addr[7:0]];
    end
    if (mem_req.wr) begin
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
    end
  end

  // Outside the answer cycle the bus shows inverted data, so a late capture never matches
  assign mem_rdata = rd_q ? q : ~q;
endmodule

//--- bench/test_bcq_seq_ops.sv
// Self-checking bench for the sequencer timer, queue, trigger, flag and flip opcodes
`timescale 1ns/1ns
module test_bcq_seq_ops;
  import bcq_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  bcq_reg_req_t reg_req = '0;
  bcq_mem_req_t mem_req;
  logic [DW-1:0] reg_rdata, mem_rdata, msg_cba;
  logic [DW-1:0] block_status = 16'h0000;
  logic cond_true = 1'b0;
  logic external_trigger_in = 1'b0;
  logic msg_done = 1'b0;
  logic msg_start;
  logic [NFLAG-1:0] gp_flags;
  logic [2:0] dly = 3'h0;
  logic [DW-1:0] rnd = 16'h002F;
  logic [DW-1:0] v, e, qp, p;
  logic [DW-1:0] w = 16'h0000;
  logic [7:0] fl = 8'h00;
  logic [2:0] res = 3'h7;
  logic c;
  int err_count = 0;
  int n_checks = 0;

  bcq_seq_ops #(.FRAME_TICK_CYCLES(10)) u_dut (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .cond_true(cond_true), .block_status(block_status), .external_trigger_in(external_trigger_in),
    .msg_done(msg_done), .msg_start(msg_start), .msg_cba(msg_cba), .gp_flags(gp_flags));
  bcq_ram_model u_ram (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

  initial begin
    forever #5 clock = ~clock;
  end

  // Far side finishes each message five cycles after it was started
  always @(posedge clock) begin
    msg_done <= (dly == 3'h1);
    if (msg_start === 1'b1) begin
      dly <= 3'h4;
    end else if (dly != 3'h0) begin
      dly <= dly - 3'h1;
    end
  end

  // ********************************************
  // Helpers
  // ********************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] flag_next(input logic [7:0] f, input logic [15:0] x);
    for (int i = 0; i < 8; i++) begin
      case ({x[i+8], x[i]})
        2'b01: f[i] = 1'b1;
        2'b10: f[i] = 1'b0;
        2'b11: f[i] = ~f[i];
        default: f[i] = f[i];
      endcase
    end
    return f;
  endfunction

  task automatic chk(input logic [15:0] ex, input logic [15:0] a);
    n_checks++;
    if (a !== ex) begin
      err_count++;
      $display("mismatch t=%0t exp=%h act=%h", $time, ex, a);
    end
  endtask

  // Timer figures drift by a tick with prescaler phase, so they are judged within a window
  task automatic chk_rng(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] a);
    n_checks++;
    if ((a >= lo && a <= hi) !== 1'b1) begin
      err_count++;
      $display("mismatch t=%0t exp=%h..%h act=%h", $time, lo, hi, a);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_req.wr <= 1'b1;
    reg_req.addr <= a;
    reg_req.wdata <= d;
    @(posedge clock);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_req.rd <= 1'b1;
    reg_req.addr <= a;
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_idle();
    logic [15:0] st;
    int n;
    n = 0;
    st = 16'hFFFF;
    while (st[0] !== 1'b0 && n < 200) begin
      reg_rd(REG_STATUS, st);
      n++;
    end
    chk(16'h0000, st & 16'h0001);
  endtask

  // One instruction at address 0; run is dropped at once so the engine stops after it
  task automatic run_op(input logic [7:0] op, input logic [15:0] par, input logic cv, input logic poll);
    u_ram.mem[0] = {8'h00, op};
    u_ram.mem[1] = par;
    cond_true <= cv;
    reg_wr(REG_INSTR_PTR, 16'h0000);
    reg_wr(REG_CONFIG, {6'h00, res, 7'h01});
    reg_wr(REG_CONFIG, {6'h00, res, 7'h00});
    if (poll) begin
      wait_idle();
      reg_rd(REG_INSTR_PTR, v);
      chk(16'h0002, v);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    final_report();
  end

  // ********************************************
  // Scenarios
  // ********************************************
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    for (int a = 0; a < 9; a++) begin
      reg_rd(a[3:0], v);
      chk(16'h0000, v);
    end
    // Engine and host flag updates share one pair encoding
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      fl = flag_next(fl, rnd);
      if (k < 8) begin
        run_op(OPC_FLAG, rnd, rnd[3], 1'b1);
      end else begin
        reg_wr(REG_GP_FLAGS, rnd);
      end
      chk({8'h00, fl}, {8'h00, gp_flags});
    end
    // Every pair at 11 toggles all flags in one write
    fl = flag_next(fl, 16'hFFFF);
    reg_wr(REG_GP_FLAGS, 16'hFFFF);
    chk({8'h00, fl}, {8'h00, gp_flags});
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      run_op(OPC_LOAD_TT, rnd, k[0], 1'b1);
      if (k[0]) begin
        w = rnd;
      end
      reg_rd(REG_TIME_TAG, v);
      chk(w, v);
    end
    // Pushes with the time tag stopped, so its pushed value is known
    reg_wr(REG_QUEUE_PTR, 16'h0080);
    qp = 16'h0080;
    u_ram.mem[8'h44] = 16'hA5C3;
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      block_status <= ~rnd;
      p = (k % 4 == 3) ? 16'h0044 : rnd;
      c = (k < 4) | rnd[2];
      case (k % 4)
        0: e = w;
        1: e = ~rnd;
        2: e = rnd;
        default: e = 16'hA5C3;
      endcase
      run_op(OPC_PUSH_TT + 8'(k % 4), p, c, 1'b1);
      if (c) begin
        chk(e, u_ram.mem[qp[7:0]]);
        qp = qp + 16'h0001;
      end
      reg_rd(REG_QUEUE_PTR, v);
      chk(qp, v);
    end
    for (int r = 4; r < 8; r++) begin
      res = r[2:0];
      reg_wr(REG_CONFIG, {6'h00, res, 7'h00});
      reg_rd(REG_TIME_TAG, w);
      repeat (2000) @(posedge clock);
      reg_rd(REG_TIME_TAG, v);
      e = (r == 7) ? 16'h0000 : 16'(20 >> (6 - r));
      chk_rng(e, e + 16'h0001, v - w);
    end
    run_op(OPC_LOAD_FT, 16'h0009, 1'b1, 1'b1);
    run_op(OPC_LOAD_FT, 16'h0123, 1'b0, 1'b1);
    reg_rd(REG_FRAME_TIMER, v);
    chk(16'h0009, v);
    run_op(OPC_START_FT, rnd, 1'b0, 1'b1);
    reg_rd(REG_FRAME_COUNT, v);
    chk(16'h0000, v);
    run_op(OPC_START_FT, rnd, 1'b1, 1'b1);
    reg_rd(REG_FRAME_COUNT, v);
    chk_rng(16'h0006, 16'h0009, v);
    // A low clock enable must freeze the running frame counter
    @(posedge clock);
    clk_en <= 1'b0;
    repeat (40) @(posedge clock);
    clk_en <= 1'b1;
    reg_rd(REG_FRAME_COUNT, v);
    chk_rng(16'h0006, 16'h0009, v);
    repeat (150) @(posedge clock);
    reg_rd(REG_FRAME_COUNT, v);
    chk(16'h0000, v);
    // A trigger already high must not release the wait; only a fresh rising edge does
    external_trigger_in <= 1'b1;
    run_op(OPC_WAIT_TRIG, rnd, 1'b1, 1'b0);
    repeat (20) @(posedge clock);
    reg_rd(REG_STATUS, v);
    chk(16'h0003, v & 16'h000F);
    external_trigger_in <= 1'b0;
    @(posedge clock);
    external_trigger_in <= 1'b1;
    wait_idle();
    run_op(OPC_WAIT_TRIG, rnd, 1'b0, 1'b1);
    p = 16'h0020;
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      c = (k < 2) ? ~k[0] : rnd[1];
      run_op(OPC_EXEC_FLIP, p, c, 1'b1);
      chk(p, msg_cba);
      if (c) begin
        p = p ^ FLIP_MASK;
      end
      chk(p, u_ram.mem[1]);
    end
    final_report();
  end
endmodule
